// file: include/gcm_pkg.sv
// gcm_pkg: constants, field layout and carrier types of the general
// configuration and mask register.
// assumes a single core clock at 200 MHz shared by every user of the package.
package gcm_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // command code and field positions
  localparam logic [7:0] CMD_GENERAL_MASK = 8'h17;
  localparam int BIT_INT_OUTPUT_ENABLE = 7;
  localparam int BIT_SPARE6 = 6;
  localparam int BIT_WIDE_ACCESS_SELECT = 5;
  localparam int BIT_MULTI_BIT_PRIORITY_SELECT = 4;
  localparam int BIT_CLASS_CHANGE_ONLY = 3;
  localparam int BIT_DETECT_CHANGE_ONLY = 2;
  localparam int BIT_SPARE1 = 1;
  localparam int BIT_SPARE0 = 0;
  localparam logic [7:0] GCM_RESET_VALUE = 8'h80;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  //////////////////////////////////////////////////////////////////////////////
  // channel grouping and result widths
  localparam int GROUP_CHANNELS = 4;
  localparam int CHANNELS = 8;
  localparam int CLASS_RESULT_W = 4;
  localparam int DETECT_RESULT_W = 3;

  //////////////////////////////////////////////////////////////////////////////
  // timing: idle time of the fast shutdown input before a priority switch
  localparam int CORE_CLK_MHZ = 200;
  localparam int OSS_IDLE_US = 200;
  localparam int OSS_IDLE_CYCLES = OSS_IDLE_US * CORE_CLK_MHZ;
  localparam int IDLE_CNT_W = 16;

  //////////////////////////////////////////////////////////////////////////////
  // types
  typedef struct packed {
    logic int_output_enable;
    logic spare6;
    logic wide_access_select;
    logic multi_bit_priority_select;
    logic class_change_only;
    logic detect_change_only;
    logic spare1;
    logic spare0;
  } gcm_cfg_t;

  typedef enum logic [1:0] {
    GCM_ST_IDLE = 2'b01,
    GCM_ST_ANSWER = 2'b10
  } gcm_acc_state_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic addr_lsb;
    logic [7:0] cmd;
    logic [15:0] wdata;
  } gcm_req_t;

  typedef struct packed {
    logic ack;
    logic nak;
    logic [15:0] rdata;
  } gcm_rsp_t;

endpackage

// file: design/gcm_reg.sv
// gcm_reg: one 8-bit instance of the configuration and mask register.
// assumes the caller has already decoded command code and target group.
`timescale 1ns/1ps
module gcm_reg (
  input wire logic core_clk, // core clock
  input wire logic rst_n, // async reset, active low
  input wire logic wr_en, // one-cycle write strobe
  input wire logic [7:0] wr_data, // byte to store
  output gcm_pkg::gcm_cfg_t cfg // stored fields
);

  gcm_pkg::gcm_cfg_t state;
  gcm_pkg::gcm_cfg_t next_state;

  //////////////////////////////////////////////////////////////////////////////
  // storage; every bit, spare ones included, is plain read/write storage
  always_comb begin
    next_state = state;
    if (wr_en) begin
      next_state = gcm_pkg::gcm_cfg_t'(wr_data);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= gcm_pkg::gcm_cfg_t'(gcm_pkg::GCM_RESET_VALUE);
    end else begin
      state <= next_state;
    end
  end

  assign cfg = state;

endmodule

// file: design/gcm_event.sv
// gcm_event: per-channel event flag set pulses from cycle completions.
// assumes done strobes and results come from logic on core_clk.
`timescale 1ns/1ps
module gcm_event #(
  parameter int CH = 8, // channel count
  parameter int RW = 4 // result width per channel
) (
  input wire logic core_clk, // core clock
  input wire logic rst_n, // async reset, active low
  input wire logic [CH-1:0] done, // cycle completed, one-cycle pulse
  input wire logic [CH*RW-1:0] result, // newest results, channel 0 lowest
  input wire logic [CH-1:0] change_only, // per channel: flag only on change
  output logic [CH-1:0] flag_set // set pulse for the event register
);

  typedef struct packed {
    logic [CH-1:0] seen;
    logic [CH*RW-1:0] last;
    logic [CH-1:0] set;
  } gcm_ev_state_t;

  gcm_ev_state_t state;
  gcm_ev_state_t next_state;

  //////////////////////////////////////////////////////////////////////////////
  // a channel with no earlier result counts its first result as a change
  always_comb begin
    next_state = state;
    next_state.set = '0;
    for (int i = 0; i < CH; i++) begin
      if (done[i]) begin
        if (change_only[i]) begin
          next_state.set[i] = !state.seen[i] || (result[i*RW +: RW] != state.last[i*RW +: RW]);
        end else begin
          next_state.set[i] = 1'b1;
        end
        next_state.last[i*RW +: RW] = result[i*RW +: RW];
        next_state.seen[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign flag_set = state.set;

endmodule

// file: design/gcm_top.sv
// gcm_top: general configuration and mask register pair of an eight-channel
// supply controller, with interrupt gating, access mode, priority mode and
// event flag qualification.
// assumes an I2C front end on core_clk that presents decoded register accesses
// and the address lsb; the fast shutdown input arrives raw from its pin.
`timescale 1ns/1ps

module gcm_top #(
  parameter int OSS_IDLE_CYCLES = gcm_pkg::OSS_IDLE_CYCLES // idle time in cycles
) (
  input wire logic core_clk, // core clock, 200 MHz
  input wire logic rst_n, // async reset, active low
  input gcm_pkg::gcm_req_t acc_req, // register access from the I2C front end
  output gcm_pkg::gcm_rsp_t acc_rsp, // answer, one cycle after acceptance
  output logic acc_busy, // high while an answer is pending
  input wire logic [7:0] int_status_lo, // interrupt bits, channels 1-4
  input wire logic [7:0] int_status_hi, // interrupt bits, channels 5-8
  input wire logic [7:0] int_mask_lo, // mask, 1 lets the bit through, 1-4
  input wire logic [7:0] int_mask_hi, // mask, 1 lets the bit through, 5-8
  output logic int_n, // interrupt output, active low
  input wire logic fast_shutdown_input, // raw fast shutdown serial pin
  output logic wide_access_mode, // 16-bit single address mode
  output logic [1:0] prio_multi, // per group: 1 = 3-bit priority
  output logic [1:0] prio_sync_risk, // per group: raised without idle input
  input wire logic [7:0] class_done, // classification completed, per channel
  input wire logic [31:0] class_result, // class results, 4 bits per channel
  input wire logic [7:0] detect_done, // detection completed, per channel
  input wire logic [23:0] detect_result, // detect results, 3 bits per channel
  output logic [7:0] class_event_flag, // set pulses for class event flags
  output logic [7:0] detect_event_flag // set pulses for detect event flags
);

  // the timer saturates at the limit, so a long idle stretch never wraps back to zero
  localparam logic [gcm_pkg::IDLE_CNT_W-1:0] IDLE_LIMIT = gcm_pkg::IDLE_CNT_W'(OSS_IDLE_CYCLES);

  typedef struct packed {
    gcm_pkg::gcm_acc_state_t acc_state;
    gcm_pkg::gcm_rsp_t rsp;
    logic int_n;
    logic oss_meta;
    logic oss_sync;
    logic [gcm_pkg::IDLE_CNT_W-1:0] idle_cnt;
    logic [1:0] prio_prev;
    logic [1:0] risk;
  } gcm_top_state_t;

  gcm_top_state_t state;
  gcm_top_state_t next_state;

  gcm_pkg::gcm_cfg_t cfg_lo;
  gcm_pkg::gcm_cfg_t cfg_hi;
  logic wr_lo;
  logic wr_hi;
  logic [7:0] wdata_lo;
  logic [7:0] wdata_hi;
  logic take;
  logic cmd_hit;
  logic addr_ok;
  logic wide;
  logic idle_ok;
  logic [7:0] cls_chg_only;
  logic [7:0] det_chg_only;
  logic acc_idle;
  logic acc_hit;
  logic [15:0] rd_word;
  logic [1:0] grp_irq;
  logic [1:0] prio_now;

  //////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic group_int(input gcm_pkg::gcm_cfg_t cfg, input logic [7:0] st,
                                     input logic [7:0] msk);
    group_int = cfg.int_output_enable && ((st & msk) != gcm_pkg::BYTE_ZERO);
  endfunction

  function automatic logic [7:0] spread(input logic lo, input logic hi);
    spread = {{gcm_pkg::GROUP_CHANNELS{hi}}, {gcm_pkg::GROUP_CHANNELS{lo}}};
  endfunction

  // risk of one group: raised on a switch to 3-bit priority before the input has idled,
  // dropped again once the group is back on 1-bit priority
  function automatic logic risk_next(input logic was_multi, input logic is_multi, input logic risk,
                                     input logic idle_done);
    risk_next = risk;
    if (!is_multi) begin
      risk_next = 1'b0;
    end
    if (is_multi && !was_multi && !idle_done) begin
      risk_next = 1'b1;
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // access decode
  // low group selects mode
  // high group bit 5 is plain storage, so the host needs to set one byte only
  assign wide = cfg_lo.wide_access_select;
  assign acc_idle = (state.acc_state == gcm_pkg::GCM_ST_IDLE);
  assign take = acc_req.valid && acc_idle;
  assign cmd_hit = (acc_req.cmd == gcm_pkg::CMD_GENERAL_MASK);
  assign addr_ok = !wide || !acc_req.addr_lsb;
  // a refused request still takes its answer cycle, so the host always sees a pulse
  assign acc_hit = cmd_hit && addr_ok;

  always_comb begin
    wr_lo = 1'b0;
    wr_hi = 1'b0;
    wdata_lo = acc_req.wdata[7:0];
    wdata_hi = acc_req.wdata[7:0];
    // a refused write stores nothing
    if (take && acc_hit && acc_req.write) begin
      if (wide) begin
        wr_lo = 1'b1;
        wr_hi = 1'b1;
        wdata_hi = acc_req.wdata[15:8];
      end else begin
        wr_lo = !acc_req.addr_lsb;
        wr_hi = acc_req.addr_lsb;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // register pair
  gcm_reg u_reg_lo (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .wr_en(wr_lo),
    .wr_data(wdata_lo),
    .cfg(cfg_lo)
  );

  gcm_reg u_reg_hi (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .wr_en(wr_hi),
    .wr_data(wdata_hi),
    .cfg(cfg_hi)
  );

  //////////////////////////////////////////////////////////////////////////////
  // read path; refused accesses and writes answer zero so stale bytes never leak
  always_comb begin
    rd_word = 16'h0000;
    if (acc_hit && !acc_req.write) begin
      case ({wide, acc_req.addr_lsb})
        2'b10: begin
          rd_word = {cfg_hi, cfg_lo};
        end
        2'b01: begin
          rd_word = {gcm_pkg::BYTE_ZERO, cfg_hi};
        end
        2'b00: begin
          rd_word = {gcm_pkg::BYTE_ZERO, cfg_lo};
        end
        default: begin
          rd_word = 16'h0000;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // interrupt request per group; status and mask come from logic on core_clk,
  // so no synchroniser sits in front of them
  // enable gates pin
  assign grp_irq = {group_int(cfg_hi, int_status_hi, int_mask_hi),
                    group_int(cfg_lo, int_status_lo, int_mask_lo)};

  //////////////////////////////////////////////////////////////////////////////
  // state update
  assign idle_ok = (state.idle_cnt >= IDLE_LIMIT);

  always_comb begin
    next_state = state;
    next_state.rsp.ack = 1'b0;
    next_state.rsp.nak = 1'b0;

    // access sequencer: one answer cycle after every accepted request
    case (state.acc_state)
      gcm_pkg::GCM_ST_IDLE: begin
        if (take) begin
          next_state.acc_state = gcm_pkg::GCM_ST_ANSWER;
          next_state.rsp.ack = acc_hit;
          next_state.rsp.nak = !acc_hit;
          next_state.rsp.rdata = rd_word;
        end
      end
      gcm_pkg::GCM_ST_ANSWER: begin
        next_state.acc_state = gcm_pkg::GCM_ST_IDLE;
      end
      default: begin
        next_state.acc_state = gcm_pkg::GCM_ST_IDLE;
      end
    endcase

    // interrupt pin; the event inputs are never touched from here
    // pin gated only
    next_state.int_n = !(|grp_irq);

    // fast shutdown pin: two-stage sync then idle-low timer
    next_state.oss_meta = fast_shutdown_input;
    next_state.oss_sync = state.oss_meta;
    if (state.oss_sync) begin
      next_state.idle_cnt = '0;
    end else if (!idle_ok) begin
      next_state.idle_cnt = state.idle_cnt + 1'b1;
    end

    // a raise of the priority bit without the idle time may desync the stream;
    // flagged only, the switch itself is never blocked
    next_state.prio_prev = prio_now;
    for (int g = 0; g < 2; g++) begin
      next_state.risk[g] = risk_next(state.prio_prev[g], prio_now[g], state.risk[g], idle_ok);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state.acc_state <= gcm_pkg::GCM_ST_IDLE;
      state.rsp <= '0;
      state.int_n <= 1'b1;
      state.oss_meta <= 1'b0;
      state.oss_sync <= 1'b0;
      state.idle_cnt <= '0;
      state.prio_prev <= 2'b00;
      state.risk <= 2'b00;
    end else begin
      state <= next_state;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // event flag qualification; channels 1-4 follow the low group's bits
  assign cls_chg_only = spread(cfg_lo.class_change_only, cfg_hi.class_change_only);
  assign det_chg_only = spread(cfg_lo.detect_change_only, cfg_hi.detect_change_only);

  gcm_event #(
    .CH(gcm_pkg::CHANNELS),
    .RW(gcm_pkg::CLASS_RESULT_W)
  ) u_class_ev (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .done(class_done),
    .result(class_result),
    .change_only(cls_chg_only),
    .flag_set(class_event_flag)
  );

  gcm_event #(
    .CH(gcm_pkg::CHANNELS),
    .RW(gcm_pkg::DETECT_RESULT_W)
  ) u_detect_ev (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .done(detect_done),
    .result(detect_result),
    .change_only(det_chg_only),
    .flag_set(detect_event_flag)
  );

  //////////////////////////////////////////////////////////////////////////////
  // outputs
  assign acc_rsp = state.rsp;
  assign acc_busy = (state.acc_state == gcm_pkg::GCM_ST_ANSWER);
  assign int_n = state.int_n;
  assign wide_access_mode = cfg_lo.wide_access_select;
  assign prio_now = {cfg_hi.multi_bit_priority_select, cfg_lo.multi_bit_priority_select};
  assign prio_multi = prio_now;
  assign prio_sync_risk = state.risk;

endmodule

// file: testbench/gcm_host.sv
// gcm_host: host side model issuing decoded register accesses.
// assumes gcm_top answers with ack or nak within a few cycles.
`timescale 1ns/1ps
module gcm_host (
  input wire logic core_clk, // core clock
  output gcm_pkg::gcm_req_t acc_req, // request to the block
  input gcm_pkg::gcm_rsp_t acc_rsp, // answer from the block
  output logic fast_shutdown_input // fast shutdown serial pin
);
  initial begin
    acc_req = '0;
    fast_shutdown_input = 1'b0;
  end
  //////////////////////////////////////////////////////////////////////////////
  // one register access, byte or 16-bit word
  task automatic xfer(input logic w, input logic lsb, input logic [7:0] cmd, input logic [15:0] wd,
                      output gcm_pkg::gcm_rsp_t r);
    int n;
    n = 0;
    @(posedge core_clk);
    acc_req <= '{valid: 1'b1, write: w, addr_lsb: lsb, cmd: cmd, wdata: wd};
    do begin
      @(posedge core_clk);
      n++;
    end while (!(acc_rsp.ack || acc_rsp.nak) && n < 8);
    r = acc_rsp;
    // released fields show inverted values so stale data is never trusted
    acc_req <= '{valid: 1'b0, write: !w, addr_lsb: !lsb, cmd: ~cmd, wdata: ~wd};
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // breaks the idle time on purpose so the risk flag has something to catch
  task automatic oss_burst(input int cycles);
    @(posedge core_clk);
    fast_shutdown_input <= 1'b1;
    repeat (cycles) @(posedge core_clk);
    fast_shutdown_input <= 1'b0;
  endtask
endmodule

// file: testbench/gcm_top_asserts.sv
// gcm_top_asserts: port level checks of the configuration register pair.
// assumes binding to gcm_top; mirrors stored bytes from taken writes.
`timescale 1ns/1ps
module gcm_top_asserts #(
  parameter int OSS_IDLE_CYCLES = 20 // idle time in cycles
) (
  input wire logic core_clk, // core clock
  input wire logic rst_n, // async reset, active low
  input gcm_pkg::gcm_req_t acc_req, // access request
  input gcm_pkg::gcm_rsp_t acc_rsp, // access answer
  input wire logic acc_busy, // answer pending
  input wire logic [7:0] int_status_lo, // status 1-4
  input wire logic [7:0] int_status_hi, // status 5-8
  input wire logic [7:0] int_mask_lo, // mask 1-4
  input wire logic [7:0] int_mask_hi, // mask 5-8
  input wire logic int_n, // interrupt, active low
  input wire logic wide_access_mode, // 16-bit mode
  input wire logic [1:0] prio_multi, // priority mode
  input wire logic [7:0] class_done, // class done
  input wire logic [7:0] detect_done, // detect done
  input wire logic [7:0] class_event_flag, // class set pulses
  input wire logic [7:0] detect_event_flag // detect set pulses
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic [7:0] sh_lo;
  logic [7:0] sh_hi;
  logic take;
  logic good;
  logic irq_want;
  logic [7:0] cls_all;
  logic [7:0] det_all;
  logic [15:0] rd_exp;
  assign take = acc_req.valid && !acc_busy;
  assign good = acc_req.cmd == gcm_pkg::CMD_GENERAL_MASK && !(wide_access_mode && acc_req.addr_lsb);
  assign irq_want = (sh_lo[7] && (int_status_lo & int_mask_lo) != 8'h00) ||
                    (sh_hi[7] && (int_status_hi & int_mask_hi) != 8'h00);
  assign cls_all = class_done & ~{{4{sh_hi[3]}}, {4{sh_lo[3]}}};
  assign det_all = detect_done & ~{{4{sh_hi[2]}}, {4{sh_lo[2]}}};
  assign rd_exp = wide_access_mode ? {sh_hi, sh_lo} : {8'h00, acc_req.addr_lsb ? sh_hi : sh_lo};
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sh_lo <= gcm_pkg::GCM_RESET_VALUE;
      sh_hi <= gcm_pkg::GCM_RESET_VALUE;
    end else if (take && good && acc_req.write) begin
      if (wide_access_mode) begin
        sh_lo <= acc_req.wdata[7:0];
        sh_hi <= acc_req.wdata[15:8];
      end else if (acc_req.addr_lsb) begin
        sh_hi <= acc_req.wdata[7:0];
      end else begin
        sh_lo <= acc_req.wdata[7:0];
      end
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  property p_int_gate;
    int_n == !$past(irq_want);
  endproperty
  a_int_gate: assert property (p_int_gate) else $error("interrupt output wrong");
  property p_wide;
    wide_access_mode == sh_lo[5];
  endproperty
  a_wide: assert property (p_wide) else $error("access mode wrong");
  property p_prio;
    prio_multi == {sh_hi[4], sh_lo[4]};
  endproperty
  a_prio: assert property (p_prio) else $error("priority mode wrong");
  property p_cls_every;
    cls_all != 8'h00 |=> (class_event_flag & $past(cls_all)) == $past(cls_all);
  endproperty
  a_cls_every: assert property (p_cls_every) else $error("class flag missing");
  property p_det_every;
    det_all != 8'h00 |=> (detect_event_flag & $past(det_all)) == $past(det_all);
  endproperty
  a_det_every: assert property (p_det_every) else $error("detect flag missing");
  property p_flag_cause;
    (class_event_flag & ~$past(class_done)) == 8'h00 && (detect_event_flag & ~$past(detect_done)) == 8'h00;
  endproperty
  a_flag_cause: assert property (p_flag_cause) else $error("flag without cycle");
  property p_ack;
    take && good |=> acc_rsp.ack && !acc_rsp.nak;
  endproperty
  a_ack: assert property (p_ack) else $error("valid access not acked");
  property p_nak;
    take && !good |=> acc_rsp.nak && !acc_rsp.ack;
  endproperty
  a_nak: assert property (p_nak) else $error("bad access not refused");
  property p_rdata;
    take && good && !acc_req.write |=> acc_rsp.rdata == $past(rd_exp);
  endproperty
  a_rdata: assert property (p_rdata) else $error("read data wrong");
endmodule

bind gcm_top gcm_top_asserts #(.OSS_IDLE_CYCLES(OSS_IDLE_CYCLES)) gcm_top_asserts_i (
  .core_clk(core_clk), .rst_n(rst_n), .acc_req(acc_req), .acc_rsp(acc_rsp), .acc_busy(acc_busy),
  .int_status_lo(int_status_lo), .int_status_hi(int_status_hi), .int_mask_lo(int_mask_lo),
  .int_mask_hi(int_mask_hi), .int_n(int_n), .wide_access_mode(wide_access_mode), .prio_multi(prio_multi),
  .class_done(class_done), .detect_done(detect_done), .class_event_flag(class_event_flag),
  .detect_event_flag(detect_event_flag));

// file: testbench/tb.sv
// tb: self-checking bench of the configuration and mask register pair.
// assumes gcm_host drives accesses; idle time shortened to 20 cycles.
`timescale 1ns/1ps
module tb;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  gcm_pkg::gcm_req_t acc_req;
  gcm_pkg::gcm_rsp_t acc_rsp;
  gcm_pkg::gcm_rsp_t r;
  logic acc_busy, int_n, wide_access_mode, fsd;
  logic [1:0] prio_multi, prio_sync_risk;
  logic [7:0] st_lo = 8'h00, st_hi = 8'h00, mk_lo = 8'h00, mk_hi = 8'h00;
  logic [7:0] c_done = 8'h00, d_done = 8'h00, c_flag, d_flag;
  logic [31:0] c_res = 32'h0000_0000;
  logic [23:0] d_res = 24'h00_0000;
  int failures = 0;
  int cmp_count = 0;
  initial forever #2.5 core_clk = ~core_clk;
  gcm_host host_i (.core_clk(core_clk), .acc_req(acc_req), .acc_rsp(acc_rsp), .fast_shutdown_input(fsd));
  gcm_top #(.OSS_IDLE_CYCLES(20)) gcm_top_i (
    .core_clk(core_clk), .rst_n(rst_n), .acc_req(acc_req), .acc_rsp(acc_rsp), .acc_busy(acc_busy),
    .int_status_lo(st_lo), .int_status_hi(st_hi), .int_mask_lo(mk_lo), .int_mask_hi(mk_hi), .int_n(int_n),
    .fast_shutdown_input(fsd), .wide_access_mode(wide_access_mode), .prio_multi(prio_multi),
    .prio_sync_risk(prio_sync_risk), .class_done(c_done), .class_result(c_res), .detect_done(d_done),
    .detect_result(d_res), .class_event_flag(c_flag), .detect_event_flag(d_flag));
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic lsb, input logic [15:0] d);
    host_i.xfer(1'b1, lsb, gcm_pkg::CMD_GENERAL_MASK, d, r);
    chk({r.nak, r.ack}, 2'b01);
  endtask
  task automatic rd(input logic lsb, input logic [15:0] exp);
    host_i.xfer(1'b0, lsb, gcm_pkg::CMD_GENERAL_MASK, 16'h0000, r);
    chk({r.nak, r.ack}, 2'b01);
    chk(r.rdata, exp);
  endtask
  task automatic pulse(input logic [7:0] cd, input logic [31:0] cr, input logic [7:0] dd,
                       input logic [23:0] dr, input logic [7:0] ec, input logic [7:0] ed);
    @(posedge core_clk);
    c_done <= cd;
    c_res <= cr;
    d_done <= dd;
    d_res <= dr;
    @(posedge core_clk);
    c_done <= 8'h00;
    d_done <= 8'h00;
    @(posedge core_clk);
    chk(c_flag, ec);
    chk(d_flag, ed);
  endtask
  task automatic settle();
    repeat (3) @(posedge core_clk);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_and_cmd();
    rd(1'b0, 16'h0080);
    rd(1'b1, 16'h0080);
    chk(wide_access_mode, 1'b0);
    chk(prio_multi, 2'b00);
    host_i.xfer(1'b1, 1'b0, 8'h16, 16'h00ff, r);
    chk({r.nak, r.ack}, 2'b10);
    rd(1'b0, 16'h0080);
  endtask
  task automatic t_spare_and_int();
    wr(1'b0, 16'h0043);
    rd(1'b0, 16'h0043);
    chk({wide_access_mode, prio_multi}, 3'b000);
    st_lo <= 8'h01;
    mk_lo <= 8'h01;
    st_hi <= 8'h20;
    settle();
    chk(int_n, 1'b1);
    pulse(8'h01, 32'h0000_0003, 8'h00, 24'h00_0000, 8'h01, 8'h00);
    wr(1'b0, 16'h0080);
    settle();
    chk(int_n, 1'b0);
    mk_lo <= 8'h00;
    mk_hi <= 8'h20;
    settle();
    chk(int_n, 1'b0);
    mk_hi <= 8'h00;
    settle();
    chk(int_n, 1'b1);
  endtask
  task automatic t_events();
    pulse(8'h01, 32'h0000_0003, 8'h01, 24'h00_0002, 8'h01, 8'h01);
    wr(1'b0, 16'h008c);
    pulse(8'h01, 32'h0000_0003, 8'h01, 24'h00_0002, 8'h00, 8'h00);
    pulse(8'h11, 32'h0000_0005, 8'h11, 24'h00_0004, 8'h11, 8'h11);
    pulse(8'h11, 32'h0000_0005, 8'h11, 24'h00_0004, 8'h10, 8'h10);
  endtask
  task automatic t_prio();
    host_i.oss_burst(3);
    wr(1'b0, 16'h0010);
    chk(prio_multi, 2'b01);
    settle();
    chk(prio_sync_risk, 2'b01);
    wr(1'b0, 16'h0000);
    repeat (30) @(posedge core_clk);
    wr(1'b0, 16'h0010);
    settle();
    chk(prio_sync_risk, 2'b00);
    wr(1'b1, 16'h0090);
    chk(prio_multi, 2'b11);
    wr(1'b0, 16'h0000);
    wr(1'b1, 16'h0080);
    chk(prio_multi, 2'b00);
  endtask
  task automatic t_wide();
    wr(1'b0, 16'h0020);
    chk(wide_access_mode, 1'b1);
    wr(1'b0, 16'h8ca0);
    rd(1'b0, 16'h8ca0);
    host_i.xfer(1'b0, 1'b1, gcm_pkg::CMD_GENERAL_MASK, 16'h0000, r);
    chk({r.nak, r.ack}, 2'b10);
    wr(1'b0, 16'h0c00);
    chk(wide_access_mode, 1'b0);
    rd(1'b1, 16'h000c);
    rd(1'b0, 16'h0000);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("comparisons %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge core_clk);
    failures++;
    tally_and_finish();
  end
  initial begin
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    t_reset_and_cmd();
    t_spare_and_int();
    t_events();
    t_prio();
    t_wide();
    tally_and_finish();
  end
endmodule
